// [msif_top.sv]
// Host interface words and mode control of a two-task motion controller
`timescale 1ns/1ps
`default_nettype none
`include "msif_params.svh"
// Functional notes
// - System error word carries the BCD error code, zero when no error.
// - Each task has its own BCD error word, zero when normal.
// - X and Y axes each have their own BCD error word, zero when normal.
// - Task one program number shown as BCD 0-999.
// - Task one block number shown as BCD 0-999.
// - Task two program and block numbers shown as BCD 0-999.
// - Task one teach execution stores first position address into its word.
// - Task two teach execution likewise stores its address, refreshed each time.
// - Task two control word bits 0-10 mirror task one functions.
// - Mode bit set means automatic mode, clear means manual mode.
// - Manual commands only in manual mode, program only in automatic.
// - Rising mode bit decelerates manually moving axes to a stop.
// - Falling mode bit stops the program and decelerates moving axes.
// - Program stopped by manual switch resumes from its block on restart.
module msif_top import msif_pkg::*; #(
  parameter int REFRESH_CYC = `MSIF_REFRESH_CYC,
  parameter int NTASK = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire msif_task_core_t [NTASK-1:0] task_core_i,
  input wire logic [15:0] sys_err_i,
  input wire logic [15:0] x_err_i,
  input wire logic [15:0] y_err_i,
  output msif_task_cmd_t [NTASK-1:0] task_cmd_o,
  output logic refresh_o,
  output logic irq_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] div_r;
  logic refresh;
  logic [`MSIF_CTRL_W-1:0] ctrl_r [NTASK];
  logic [`MSIF_CTRL_W-1:0] ctrl_prev_r [NTASK];
  logic [15:0] tstart_r [NTASK];
  logic [15:0] terr_w [NTASK];
  logic [15:0] prog_w [NTASK];
  logic [15:0] blk_w [NTASK];
  logic [15:0] texec_w [NTASK];
  logic [15:0] sys_w;
  logic [15:0] x_w;
  logic [15:0] y_w;
  logic [NTASK-1:0] auto_m;
  logic [NTASK-1:0] decel_m;
  logic [NTASK-1:0] pstop_m;
  logic [NTASK-1:0] start_m;
  logic [NTASK-1:0] resume_m;
  logic [NTASK-1:0] change_m;
  logic [NTASK-1:0] tset_r;
  logic [NTASK-1:0] texec_r;
  logic [4*NTASK-1:0] bad_t;
  logic [2:0] bad_g;
  logic [`MSIF_IRQ_W-1:0] irq_stat_r;
  logic [`MSIF_IRQ_W-1:0] irq_mask_r;
  logic [`MSIF_IRQ_W-1:0] irq_evt;
  logic [15:0] rd_nxt;

  // ----------------------------------------
  // Refresh divider
  // ----------------------------------------
  // One refresh pulse per period paces status sampling, except the teach execution words loaded on teach done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 16'h0000;
    end else if (refresh) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  assign refresh = (div_r == 16'(REFRESH_CYC - 1));
  assign refresh_o = refresh;

  // ----------------------------------------
  // Global status words
  // ----------------------------------------
  // system error word
  msif_bcd_word #(.MAX(`MSIF_ERR_MAX)) u_sys (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(refresh),
    .value_i(sys_err_i),
    .word_o(sys_w),
    .bad_o(bad_g[0])
  );

  msif_bcd_word #(.MAX(`MSIF_ERR_MAX)) u_xerr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(refresh),
    .value_i(x_err_i),
    .word_o(x_w),
    .bad_o(bad_g[1])
  );

  msif_bcd_word #(.MAX(`MSIF_ERR_MAX)) u_yerr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(refresh),
    .value_i(y_err_i),
    .word_o(y_w),
    .bad_o(bad_g[2])
  );

  // ----------------------------------------
  // Per-task logic
  // ----------------------------------------
  for (genvar t = 0; t < NTASK; t++) begin : g_task
    msif_bcd_word #(.MAX(`MSIF_ERR_MAX)) u_terr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(refresh),
      .value_i(task_core_i[t].error_code),
      .word_o(terr_w[t]),
      .bad_o(bad_t[4*t])
    );

    msif_bcd_word #(.MAX(`MSIF_PROG_MAX)) u_prog (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(refresh),
      .value_i(task_core_i[t].program_no),
      .word_o(prog_w[t]),
      .bad_o(bad_t[4*t+1])
    );

    msif_bcd_word #(.MAX(`MSIF_PROG_MAX)) u_blk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(refresh),
      .value_i(task_core_i[t].block_no),
      .word_o(blk_w[t]),
      .bad_o(bad_t[4*t+2])
    );

    msif_bcd_word #(.MAX(`MSIF_ADDR_MAX)) u_texec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(task_core_i[t].teach_done),
      .value_i(task_core_i[t].teach_addr),
      .word_o(texec_w[t]),
      .bad_o(bad_t[4*t+3])
    );

    msif_mode_ctl u_mode (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .refresh_i(refresh),
      .mode_bit_i(ctrl_r[t][`MSIF_CTRL_MODE]),
      .start_bit_i(ctrl_r[t][`MSIF_CTRL_START]),
      .running_i(task_core_i[t].program_running),
      .manual_moving_i(task_core_i[t].manual_moving),
      .moving_i(task_core_i[t].axes_moving),
      .auto_o(auto_m[t]),
      .decel_stop_o(decel_m[t]),
      .program_stop_o(pstop_m[t]),
      .start_o(start_m[t]),
      .resume_o(resume_m[t]),
      .change_o(change_m[t])
    );

    // Teach set and execute act on the rising bit at refresh
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctrl_prev_r[t] <= '0;
        tset_r[t] <= 1'b0;
        texec_r[t] <= 1'b0;
      end else begin
        tset_r[t] <= 1'b0;
        texec_r[t] <= 1'b0;
        if (refresh) begin
          ctrl_prev_r[t] <= ctrl_r[t];
          tset_r[t] <= ctrl_r[t][`MSIF_CTRL_TSET] & ~ctrl_prev_r[t][`MSIF_CTRL_TSET];
          texec_r[t] <= ctrl_r[t][`MSIF_CTRL_TEXEC] & ~ctrl_prev_r[t][`MSIF_CTRL_TEXEC];
        end
      end
    end

    // Command bundle toward the motion core
    always_comb begin
      task_cmd_o[t].auto_mode = auto_m[t];
      task_cmd_o[t].manual_en = ~auto_m[t];
      task_cmd_o[t].program_en = auto_m[t];
      task_cmd_o[t].decel_stop = decel_m[t];
      task_cmd_o[t].program_stop = pstop_m[t];
      task_cmd_o[t].start = start_m[t];
      task_cmd_o[t].resume = resume_m[t];
      task_cmd_o[t].teach_set = tset_r[t];
      task_cmd_o[t].teach_exec = texec_r[t];
      task_cmd_o[t].teach_start_addr = tstart_r[t];
      task_cmd_o[t].ctrl_bits = ctrl_r[t];
    end
  end

  // ----------------------------------------
  // Host-written words
  // ----------------------------------------
  // Start address kept as written; range is the host's duty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NTASK; i++) begin
        ctrl_r[i] <= '0;
        tstart_r[i] <= `MSIF_BCD_ZERO;
      end
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `MSIF_OFF_T1_CTRL: ctrl_r[0] <= reg_wdata_i[`MSIF_CTRL_W-1:0];
        `MSIF_OFF_T2_CTRL: ctrl_r[1] <= reg_wdata_i[`MSIF_CTRL_W-1:0];
        `MSIF_OFF_T1_TSTART: tstart_r[0] <= reg_wdata_i;
        `MSIF_OFF_T2_TSTART: tstart_r[1] <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Errors flag only on the step from normal to faulted
  always_comb begin
    irq_evt = '0;
    irq_evt[`MSIF_IRQ_SYS] = refresh & (sys_err_i != `MSIF_BCD_ZERO) & (sys_w == `MSIF_BCD_ZERO);
    for (int i = 0; i < NTASK; i++) begin
      irq_evt[`MSIF_IRQ_T1ERR+i] = refresh & (task_core_i[i].error_code != `MSIF_BCD_ZERO) &
                                    (terr_w[i] == `MSIF_BCD_ZERO);
      irq_evt[`MSIF_IRQ_TEACH+i] = task_core_i[i].teach_done;
      irq_evt[`MSIF_IRQ_MODE+i] = change_m[i];
    end
    irq_evt[`MSIF_IRQ_XERR] = refresh & (((x_err_i != `MSIF_BCD_ZERO) & (x_w == `MSIF_BCD_ZERO)) |
                                         ((y_err_i != `MSIF_BCD_ZERO) & (y_w == `MSIF_BCD_ZERO)));
    irq_evt[`MSIF_IRQ_FMT] = (|bad_t) | (|bad_g);
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (reg_wr_i && reg_addr_i == `MSIF_OFF_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~reg_wdata_i[`MSIF_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (reg_wr_i && reg_addr_i == `MSIF_OFF_IRQ_MASK) begin
      irq_mask_r <= reg_wdata_i[`MSIF_IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped words read zero
  always_comb begin
    case (reg_addr_i)
      `MSIF_OFF_T1_CTRL: rd_nxt = 16'(ctrl_r[0]);
      `MSIF_OFF_T2_CTRL: rd_nxt = 16'(ctrl_r[1]);
      `MSIF_OFF_T1_TSTART: rd_nxt = tstart_r[0];
      `MSIF_OFF_T2_TSTART: rd_nxt = tstart_r[1];
      `MSIF_OFF_SYS_ERR: rd_nxt = sys_w;
      `MSIF_OFF_T1_ERR: rd_nxt = terr_w[0];
      `MSIF_OFF_T2_ERR: rd_nxt = terr_w[1];
      `MSIF_OFF_X_ERR: rd_nxt = x_w;
      `MSIF_OFF_Y_ERR: rd_nxt = y_w;
      `MSIF_OFF_T1_PROG: rd_nxt = prog_w[0];
      `MSIF_OFF_T1_BLK: rd_nxt = blk_w[0];
      `MSIF_OFF_T1_TEXEC: rd_nxt = texec_w[0];
      `MSIF_OFF_T2_PROG: rd_nxt = prog_w[1];
      `MSIF_OFF_T2_BLK: rd_nxt = blk_w[1];
      `MSIF_OFF_T2_TEXEC: rd_nxt = texec_w[1];
      `MSIF_OFF_IRQ_STAT: rd_nxt = 16'(irq_stat_r);
      `MSIF_OFF_IRQ_MASK: rd_nxt = 16'(irq_mask_r);
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [msif_params.svh]
// Constants of the motion task status and mode interface
`ifndef MSIF_PARAMS_SVH
`define MSIF_PARAMS_SVH
// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define MSIF_OFF_T1_CTRL 8'h01
`define MSIF_OFF_T2_CTRL 8'h03
`define MSIF_OFF_T1_TSTART 8'h0A
`define MSIF_OFF_T2_TSTART 8'h0B
`define MSIF_OFF_SYS_ERR 8'h0C
`define MSIF_OFF_T1_ERR 8'h0D
`define MSIF_OFF_T2_ERR 8'h0E
`define MSIF_OFF_X_ERR 8'h0F
`define MSIF_OFF_Y_ERR 8'h10
`define MSIF_OFF_T1_PROG 8'h11
`define MSIF_OFF_T1_BLK 8'h12
`define MSIF_OFF_T1_TEXEC 8'h13
`define MSIF_OFF_T2_PROG 8'h14
`define MSIF_OFF_T2_BLK 8'h15
`define MSIF_OFF_T2_TEXEC 8'h16
`define MSIF_OFF_IRQ_STAT 8'h20
`define MSIF_OFF_IRQ_MASK 8'h21
// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define MSIF_CTRL_W 11
`define MSIF_CTRL_MODE 1
`define MSIF_CTRL_START 2
`define MSIF_CTRL_TSET 8
`define MSIF_CTRL_TEXEC 9
`define MSIF_IRQ_W 9
`define MSIF_IRQ_SYS 0
`define MSIF_IRQ_T1ERR 1
`define MSIF_IRQ_XERR 3
`define MSIF_IRQ_TEACH 4
`define MSIF_IRQ_MODE 6
`define MSIF_IRQ_FMT 8
// ----------------------------------------
// Reset values and BCD limits
// ----------------------------------------
`define MSIF_BCD_ZERO 16'h0000
`define MSIF_ADDR_MAX 16'h1999
`define MSIF_PROG_MAX 16'h0999
`define MSIF_ERR_MAX 16'h9999
`define MSIF_NIB_MAX 4'h9
// ----------------------------------------
// Timing: interface refresh period
// ----------------------------------------
`define MSIF_CLK_MHZ 250
`define MSIF_REFRESH_NS 1000
`define MSIF_REFRESH_CYC ((`MSIF_REFRESH_NS * `MSIF_CLK_MHZ) / 1000)
`endif

// [msif_pkg.sv]
// Types and helpers of the motion task status and mode interface
`include "msif_params.svh"
package msif_pkg;
  // Per-task status coming from the motion core
  typedef struct packed {
    logic program_running;
    logic manual_moving;
    logic axes_moving;
    logic teach_done;
    logic [15:0] teach_addr;
    logic [15:0] error_code;
    logic [15:0] program_no;
    logic [15:0] block_no;
  } msif_task_core_t;

  // Per-task commands toward the motion core
  typedef struct packed {
    logic auto_mode;
    logic manual_en;
    logic program_en;
    logic decel_stop;
    logic program_stop;
    logic start;
    logic resume;
    logic teach_set;
    logic teach_exec;
    logic [15:0] teach_start_addr;
    logic [10:0] ctrl_bits;
  } msif_task_cmd_t;

  // Mode state, held variants remember a stopped program
  typedef enum logic [3:0] {
    MSIF_ST_MAN = 4'h1,
    MSIF_ST_MAN_HELD = 4'h2,
    MSIF_ST_AUTO = 4'h4,
    MSIF_ST_AUTO_HELD = 4'h8
  } msif_mode_state_t;

  // Valid 4-digit BCD not above a BCD limit
  function automatic logic msif_bcd_ok(input logic [15:0] v, input logic [15:0] lim);
    logic ok;
    ok = (v[15:12] <= `MSIF_NIB_MAX) && (v[11:8] <= `MSIF_NIB_MAX) &&
         (v[7:4] <= `MSIF_NIB_MAX) && (v[3:0] <= `MSIF_NIB_MAX);
    // Valid BCD orders the same as binary
    return ok && (v <= lim);
  endfunction
endpackage

// [msif_bcd_word.sv]
// Status word holding a checked 4-digit BCD value
`timescale 1ns/1ps
`default_nettype none
`include "msif_params.svh"
module msif_bcd_word import msif_pkg::*; #(
  parameter logic [15:0] MAX = `MSIF_ADDR_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] value_i,
  output logic [15:0] word_o,
  output logic bad_o
);
  // ----------------------------------------
  // Capture
  // ----------------------------------------
  // A malformed value keeps the last good word and flags it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_o <= `MSIF_BCD_ZERO;
      bad_o <= 1'b0;
    end else begin
      bad_o <= 1'b0;
      if (load_i) begin
        if (msif_bcd_ok(value_i, MAX)) begin
          word_o <= value_i;
        end else begin
          bad_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [msif_mode_ctl.sv]
// Automatic/manual mode sequencing for one task
`timescale 1ns/1ps
`default_nettype none
`include "msif_params.svh"
module msif_mode_ctl import msif_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic refresh_i,
  input wire logic mode_bit_i,
  input wire logic start_bit_i,
  input wire logic running_i,
  input wire logic manual_moving_i,
  input wire logic moving_i,
  output logic auto_o,
  output logic decel_stop_o,
  output logic program_stop_o,
  output logic start_o,
  output logic resume_o,
  output logic change_o
);
  msif_mode_state_t state_r;
  logic mode_prev_r;
  logic start_prev_r;
  logic rise;
  logic fall;
  logic srise;

  // ----------------------------------------
  // Edge detection per refresh
  // ----------------------------------------
  // compare with previous refresh sample
  assign rise = refresh_i & mode_bit_i & ~mode_prev_r;
  assign fall = refresh_i & ~mode_bit_i & mode_prev_r;
  assign srise = refresh_i & start_bit_i & ~start_prev_r;

  // Samples taken only on refresh, so host glitches are missed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_prev_r <= 1'b0;
      start_prev_r <= 1'b0;
    end else if (refresh_i) begin
      mode_prev_r <= mode_bit_i;
      start_prev_r <= start_bit_i;
    end
  end

  // ----------------------------------------
  // Mode state
  // ----------------------------------------
  // mode follows the bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= MSIF_ST_MAN;
    end else begin
      case (state_r)
        MSIF_ST_MAN: if (rise) state_r <= MSIF_ST_AUTO;
        MSIF_ST_MAN_HELD: if (rise) state_r <= MSIF_ST_AUTO_HELD;
        MSIF_ST_AUTO: begin
          if (fall) state_r <= running_i ? MSIF_ST_MAN_HELD : MSIF_ST_MAN;
        end
        MSIF_ST_AUTO_HELD: begin
          if (fall) state_r <= MSIF_ST_MAN_HELD;
          else if (srise) state_r <= MSIF_ST_AUTO;
        end
        default: state_r <= MSIF_ST_MAN;
      endcase
    end
  end

  assign auto_o = (state_r == MSIF_ST_AUTO) | (state_r == MSIF_ST_AUTO_HELD);

  // ----------------------------------------
  // One-cycle commands
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decel_stop_o <= 1'b0;
      program_stop_o <= 1'b0;
      start_o <= 1'b0;
      resume_o <= 1'b0;
      change_o <= 1'b0;
    end else begin
      decel_stop_o <= (rise & manual_moving_i) | (fall & moving_i);
      program_stop_o <= fall & running_i;
      start_o <= srise & (state_r == MSIF_ST_AUTO) & ~running_i & ~fall;
      resume_o <= srise & (state_r == MSIF_ST_AUTO_HELD) & ~fall;
      change_o <= rise | fall;
    end
  end
endmodule
`default_nettype wire

// [msif_top_chk.sv]
// Assertion checker for the motion task status and mode interface
`timescale 1ns/1ps
`default_nettype none
module msif_top_chk import msif_pkg::*; #(
  parameter int REFRESH_CYC = 4,
  parameter int NTASK = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire msif_task_core_t [NTASK-1:0] task_core_i,
  input wire msif_task_cmd_t [NTASK-1:0] task_cmd_o,
  input wire logic refresh_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Refresh spacing helper
  // ----------------------------------------
  logic [15:0] gap_r;
  logic seen_r;
  // First pulse skipped, its spacing is counted from reset rather than from an earlier pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || refresh_o)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_r + 16'h0001;
    seen_r <= !rst_i && (seen_r || refresh_o);
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_refresh; refresh_o && seen_r |-> gap_r == REFRESH_CYC - 1; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh spacing wrong");
  property p_mode_edge; $changed(task_cmd_o[0].auto_mode) |->
    $past(refresh_o) && task_cmd_o[0].auto_mode == $past(task_cmd_o[0].ctrl_bits[1]); endproperty
  a_mode_edge: assert property (p_mode_edge) else $error("mode change off refresh");
  property p_mode_en; task_cmd_o[0].manual_en == !task_cmd_o[0].auto_mode &&
    task_cmd_o[0].program_en == task_cmd_o[0].auto_mode; endproperty
  a_mode_en: assert property (p_mode_en) else $error("manual or program enable wrong");
  property p_rise_decel; $rose(task_cmd_o[0].auto_mode) |->
    task_cmd_o[0].decel_stop == $past(task_core_i[0].manual_moving); endproperty
  a_rise_decel: assert property (p_rise_decel) else $error("no stop on rise");
  property p_fall_stop; $fell(task_cmd_o[0].auto_mode) |->
    task_cmd_o[0].program_stop == $past(task_core_i[0].program_running); endproperty
  a_fall_stop: assert property (p_fall_stop) else $error("no program stop on fall");
  property p_fall_decel; $fell(task_cmd_o[0].auto_mode) |->
    task_cmd_o[0].decel_stop == $past(task_core_i[0].axes_moving); endproperty
  a_fall_decel: assert property (p_fall_decel) else $error("no axis stop on fall");
  property p_pulse; task_cmd_o[0].decel_stop |=> !task_cmd_o[0].decel_stop; endproperty
  a_pulse: assert property (p_pulse) else $error("stop pulse too long");
  property p_start; task_cmd_o[0].start || task_cmd_o[0].resume |-> $past(refresh_o) &&
    task_cmd_o[0].auto_mode && !(task_cmd_o[0].start && task_cmd_o[0].resume); endproperty
  a_start: assert property (p_start) else $error("start or resume out of place");
  property p_teach; task_cmd_o[0].teach_exec |-> $past(refresh_o) &&
    $past(task_cmd_o[0].ctrl_bits[9]); endproperty
  a_teach: assert property (p_teach) else $error("teach execute without cause");
  property p_t2_rise; $rose(task_cmd_o[1].auto_mode) |->
    task_cmd_o[1].decel_stop == $past(task_core_i[1].manual_moving); endproperty
  a_t2_rise: assert property (p_t2_rise) else $error("task two rise wrong");
endmodule
bind msif_top msif_top_chk #(.REFRESH_CYC(REFRESH_CYC), .NTASK(NTASK)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .task_core_i(task_core_i), .task_cmd_o(task_cmd_o), .refresh_o(refresh_o));
`default_nettype wire

// [msif_core_model.sv]
// Behavioural motion core model facing the interface block
`timescale 1ns/1ps
`default_nettype none
module msif_core_model import msif_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire msif_task_core_t [1:0] cfg_i,
  input wire msif_task_cmd_t [1:0] cmd_i,
  output msif_task_core_t [1:0] core_o
);
  logic [1:0] run_r;
  logic [1:0] done_r;
  logic [15:0] taddr_r [2];
  // program runs only once started or resumed
  // teach done pulse carries the start address
  always_ff @(posedge clk_i) begin
    for (int t = 0; t < 2; t++) begin
      if (rst_i) begin
        run_r[t] <= 1'b0;
        done_r[t] <= 1'b0;
        taddr_r[t] <= 16'h0000;
      end else begin
        if (cmd_i[t].program_stop)
          run_r[t] <= 1'b0;
        else if (cmd_i[t].start || cmd_i[t].resume)
          run_r[t] <= 1'b1;
        done_r[t] <= cmd_i[t].teach_exec;
        if (cmd_i[t].teach_exec)
          taddr_r[t] <= cmd_i[t].teach_start_addr;
      end
    end
  end
  // Static codes from the bench, motion from the model
  always_comb begin
    core_o = cfg_i;
    for (int t = 0; t < 2; t++) begin
      core_o[t].program_running = run_r[t];
      core_o[t].axes_moving = run_r[t] | cfg_i[t].manual_moving;
      core_o[t].teach_done = done_r[t];
      core_o[t].teach_addr = taddr_r[t];
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the motion task status and mode interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
`define WAITC(c) begin wk = 0; while (((c) !== 1'b1) && wk < 60) begin @(posedge clk_i); #1; wk++; end \
  `CHK("wait", 1'b1, wk < 60) end
module tb_top import msif_pkg::*; ();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] sys_err_i = 16'h0000;
  logic [15:0] x_err_i = 16'h0000;
  logic [15:0] y_err_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic [15:0] rv;
  logic refresh_o;
  logic irq_o;
  msif_task_core_t [1:0] cfg = '0;
  msif_task_core_t [1:0] core;
  msif_task_cmd_t [1:0] cmd;
  int n_mismatch = 0;
  int cmp_count = 0;
  int wk;
  // Small refresh period keeps the run short
  always #2 clk_i = ~clk_i;
  msif_top #(.REFRESH_CYC(4), .NTASK(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .task_core_i(core), .sys_err_i(sys_err_i), .x_err_i(x_err_i), .y_err_i(y_err_i),
    .task_cmd_o(cmd), .refresh_o(refresh_o), .irq_o(irq_o));
  msif_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .cmd_i(cmd), .core_o(core));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [15:0] ex);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rv = reg_rdata_o;
    `CHK(nm, ex, rv)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int a = 8'h0A; a <= 8'h16; a++)
      chk_rd("reset word", a[7:0], 16'h0000);
    chk_rd("irq status", 8'h20, 16'h0000);
    chk_rd("unmapped", 8'h30, 16'h0000);
    `CHK("irq out", 1'b0, irq_o)
    $display("t_reset done");
  endtask
  task automatic t_status();
    @(posedge clk_i);
    sys_err_i <= 16'h9999;
    x_err_i <= 16'h0501;
    y_err_i <= 16'h0003;
    cfg[0].error_code <= 16'h0042;
    cfg[1].error_code <= 16'h1234;
    cfg[0].program_no <= 16'h0999;
    cfg[0].block_no <= 16'h0456;
    cfg[1].program_no <= 16'h0007;
    cfg[1].block_no <= 16'h0890;
    wait_cyc(10);
    chk_rd("sys err", 8'h0C, 16'h9999);
    chk_rd("t1 err", 8'h0D, 16'h0042);
    chk_rd("t2 err", 8'h0E, 16'h1234);
    chk_rd("x err", 8'h0F, 16'h0501);
    chk_rd("y err", 8'h10, 16'h0003);
    chk_rd("t1 prog", 8'h11, 16'h0999);
    chk_rd("t1 blk", 8'h12, 16'h0456);
    chk_rd("t2 prog", 8'h14, 16'h0007);
    chk_rd("t2 blk", 8'h15, 16'h0890);
    // Out of range and non-decimal digit are both refused
    cfg[0].program_no <= 16'h1000;
    cfg[0].block_no <= 16'h00A1;
    wr(8'h0C, 16'h0000);
    wait_cyc(10);
    chk_rd("prog kept", 8'h11, 16'h0999);
    chk_rd("blk kept", 8'h12, 16'h0456);
    chk_rd("ro word", 8'h0C, 16'h9999);
    chk_rd("status", 8'h20, 16'h010F);
    `CHK("irq masked", 1'b0, irq_o)
    $display("t_status done");
  endtask
  task automatic t_irq();
    wr(8'h21, 16'h0001);
    `CHK("irq on", 1'b1, irq_o)
    wr(8'h20, 16'h0001);
    chk_rd("w1c", 8'h20, 16'h010E);
    `CHK("irq off", 1'b0, irq_o)
    wr(8'h21, 16'h0100);
    `CHK("irq fmt", 1'b1, irq_o)
    // Valid codes again, else the format event refires on each refresh
    cfg[0].program_no <= 16'h0999;
    cfg[0].block_no <= 16'h0456;
    wait_cyc(6);
    wr(8'h20, 16'h01FF);
    chk_rd("clear", 8'h20, 16'h0000);
    `CHK("irq idle", 1'b0, irq_o)
    $display("t_irq done");
  endtask
  task automatic t_mode();
    cfg[0].manual_moving <= 1'b1;
    wr(8'h01, 16'h0002);
    `WAITC(cmd[0].auto_mode)
    `CHK("rise decel", 1'b1, cmd[0].decel_stop)
    `CHK("manual off", 1'b0, cmd[0].manual_en)
    cfg[0].manual_moving <= 1'b0;
    wr(8'h01, 16'h0006);
    `WAITC(cmd[0].start)
    `WAITC(core[0].program_running)
    wr(8'h01, 16'h0004);
    `WAITC(!cmd[0].auto_mode)
    `CHK("fall stop", 1'b1, cmd[0].program_stop)
    `CHK("fall decel", 1'b1, cmd[0].decel_stop)
    // Start bit dropped first so the return gets a fresh rise
    wr(8'h01, 16'h0002);
    `WAITC(cmd[0].auto_mode)
    `CHK("idle rise", 1'b0, cmd[0].decel_stop)
    wr(8'h01, 16'h0006);
    `WAITC(cmd[0].start || cmd[0].resume)
    `CHK("resume", 1'b1, cmd[0].resume)
    wr(8'h03, 16'h0002);
    `WAITC(cmd[1].auto_mode)
    `CHK("t2 bits", 11'h002, cmd[1].ctrl_bits)
    chk_rd("t2 ctrl", 8'h03, 16'h0002);
    chk_rd("mode irq", 8'h20, 16'h00C0);
    $display("t_mode done");
  endtask
  task automatic t_teach();
    wr(8'h20, 16'h01FF);
    // Start addresses placed before the set bit rises
    wr(8'h0A, 16'h1999);
    wr(8'h0B, 16'h0742);
    chk_rd("t1 start", 8'h0A, 16'h1999);
    wr(8'h01, 16'h0106);
    `WAITC(cmd[0].teach_set)
    `CHK("set addr", 16'h1999, cmd[0].teach_start_addr)
    wr(8'h01, 16'h0306);
    `WAITC(cmd[0].teach_exec)
    wait_cyc(4);
    chk_rd("t1 exec", 8'h13, 16'h1999);
    wr(8'h03, 16'h0202);
    `WAITC(cmd[1].teach_exec)
    wait_cyc(4);
    chk_rd("t2 exec", 8'h16, 16'h0742);
    wr(8'h0B, 16'h0100);
    wr(8'h03, 16'h0002);
    wait_cyc(10);
    wr(8'h03, 16'h0202);
    `WAITC(cmd[1].teach_exec)
    wait_cyc(4);
    chk_rd("t2 again", 8'h16, 16'h0100);
    chk_rd("teach irq", 8'h20, 16'h0030);
    $display("t_teach done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_cyc(2);
    t_reset();
    t_status();
    t_irq();
    t_mode();
    t_teach();
    report_and_stop();
  end
endmodule
`default_nettype wire
